//--- line_pick.sv
// Picks one of four trigger lines and reports its rising edge as a pulse.
`timescale 1ns/10ps
`include "trigger_router_map.svh"
module line_pick
(
	// Clock and reset
	input  wire logic                          ref_clk_in,
	input  wire logic                          arst_n_in,
	// Lines and selection
	input  wire logic [`RTR_LINE_COUNT-1:0]    lines_in,
	input  wire trigger_router_pkg::line_num_t line_num_in,
	// Edge seen on the selected line
	output logic                               pulse_out
);
	import trigger_router_pkg::*;

	logic [`RTR_LINE_COUNT-1:0] level;
	logic [`RTR_LINE_COUNT-1:0] rise;

	// Edges are kept for every line so that changing the selection
	// cannot fake an edge.
	assign rise = lines_in & ~level;

	always_ff @(posedge ref_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			level <= '0;
		else
			level <= lines_in;
	end

	always_ff @(posedge ref_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			pulse_out <= 1'b0;
		else
			pulse_out <= rise[2'(line_num_in - `RTR_LINE_FIRST)];
	end

endmodule // line_pick

//--- router_monitor.sv
// Concurrent checks on the ports of the trigger line event router.
`timescale 1ns/10ps
`include "trigger_router_map.svh"
module router_monitor
	import trigger_router_pkg::*;
(
	// Clock and reset
	input  wire logic                              ref_clk_in,
	input  wire logic                              arst_n_in,
	// Register bus
	input  wire trigger_router_pkg::reg_req_t      bus_req_in,
	input  wire logic [`RTR_DATA_W-1:0]            rd_data_out,
	// Trigger model sequencer
	input  wire trigger_router_pkg::model_events_t model_events_in,
	input  wire trigger_router_pkg::sdm_set_t      detector_req_in,
	input  wire logic                              arm_wait_in,
	input  wire trigger_router_pkg::sdm_set_t      detector_go_out,
	input  wire logic                              arm_go_out,
	// Shared trigger lines
	input  wire logic [`RTR_LINE_COUNT-1:0]        lines_in,
	input  wire logic [`RTR_LINE_COUNT-1:0]        lines_out,
	input  wire logic [`RTR_LINE_COUNT-1:0]        lines_oe_out
);
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!arst_n_in);

	oe_mirror_a: assert property (
		lines_oe_out == lines_out)
		else $error("Line enable differs from line drive.");
	pulse_cause_a: assert property (
		lines_out != 4'h0 |-> $past(model_events_in) != '0)
		else $error("Line pulse without an event.");
	pulse_width_a: assert property (
		lines_out != 4'h0 && $past(lines_out) != 4'h0
		|-> $past(model_events_in, 2) != '0)
		else $error("Line pulse longer than its events.");
	go_cause_a: assert property (
		(detector_go_out & ~$past(detector_req_in)) == 3'h0)
		else $error("Detector pass without a request.");
	go_single_a: assert property (
		(detector_go_out & $past(detector_go_out)) == 3'h0)
		else $error("Detector pass longer than one cycle.");
	arm_cause_a: assert property (
		arm_go_out |-> $past(arm_wait_in))
		else $error("Arm pass without a wait.");
	arm_single_a: assert property (
		arm_go_out |=> !arm_go_out)
		else $error("Arm pass longer than one cycle.");
	rd_idle_a: assert property (
		!$past(bus_req_in.rd) |-> rd_data_out == 8'h00)
		else $error("Read data outside the read answer cycle.");
	unmapped_a: assert property (
		bus_req_in.rd && bus_req_in.addr > 5'h18 |=> rd_data_out == 8'h00)
		else $error("Unmapped read returned data.");
endmodule // router_monitor

bind trigger_line_event_router router_monitor router_monitor_inst
(
	.ref_clk_in      (ref_clk_in),
	.arst_n_in       (arst_n_in),
	.bus_req_in      (bus_req_in),
	.rd_data_out     (rd_data_out),
	.model_events_in (model_events_in),
	.detector_req_in (detector_req_in),
	.arm_wait_in     (arm_wait_in),
	.detector_go_out (detector_go_out),
	.arm_go_out      (arm_go_out),
	.lines_in        (lines_in),
	.lines_out       (lines_out),
	.lines_oe_out    (lines_oe_out)
);

//--- trig_line_peer.sv
// Other instruments on the shared trigger lines.
`timescale 1ns/10ps
module trig_line_peer
(
	// Clock
	input  wire logic       ref_clk_in,
	// Device drive
	input  wire logic [3:0] dev_out_in,
	input  wire logic [3:0] dev_oe_in,
	// Resolved line levels
	output logic      [3:0] level_out
);
	logic [3:0] drv = 4'h0;

	// Lines idle low; the device adds its pulse while it drives.
	assign level_out = drv | (dev_oe_in & dev_out_in);

	// Sends a two-cycle high pulse on line n, numbered 1 to 4.
	task automatic fire(input int n);
		@(posedge ref_clk_in);
		drv[n-1] <= 1'b1;
		repeat (2) @(posedge ref_clk_in);
		drv <= 4'h0;
	endtask
endmodule // trig_line_peer

//--- trigger_line_event_router.sv
// Trigger line event router: line selection, output events and detectors.
//
// The register offsets and the strobed register port were chosen for this implementation.
`timescale 1ns/10ps
`include "trigger_router_map.svh"

// ==========================================================================
// Overview of operation
// RULE1: separate input line per layer, lines 1-4
// RULE2: separate output line per layer, lines 1-4
// RULE3: configurer keeps input and output lines apart; the code does not check this and accepts the same line number for both
// RULE4: enter option pulses on entering trigger layer
// RULE5: leave option pulses on leaving trigger layer
// RULE6: none option drives no arm layer pulses
// RULE7: source event pulses after source applied
// RULE8: delay event pulses after delay expired
// RULE9: measure event pulses after measurement done
// RULE10: any combination of trigger layer events
// RULE11: none disables only when given alone
// RULE12: external source stalls enabled detectors until pulse
// RULE13: each output pulse lasts one clock; events on consecutive clocks keep the line driven for as many clocks
module trigger_line_event_router
(
	// Clock and reset
	input  wire logic                              ref_clk_in,
	input  wire logic                              arst_n_in,
	// Register bus
	input  wire trigger_router_pkg::reg_req_t      bus_req_in,
	output logic [`RTR_DATA_W-1:0]                 rd_data_out,
	// Trigger model sequencer
	input  wire trigger_router_pkg::model_events_t model_events_in,
	input  wire trigger_router_pkg::sdm_set_t      detector_req_in,
	input  wire logic                              arm_wait_in,
	output trigger_router_pkg::sdm_set_t           detector_go_out,
	output logic                                   arm_go_out,
	// Shared trigger lines
	input  wire logic [`RTR_LINE_COUNT-1:0]        lines_in,
	output logic [`RTR_LINE_COUNT-1:0]             lines_out,
	output logic [`RTR_LINE_COUNT-1:0]             lines_oe_out
);
	import trigger_router_pkg::*;

	// ======================================================================
	// Configuration state
	line_num_t               arm_in_line;
	line_num_t               arm_out_line;
	line_num_t               trig_in_line;
	line_num_t               trig_out_line;
	logic [`RTR_ARM_EV_W-1:0] arm_event_mode;
	sdm_set_t                trig_out_events;
	sdm_set_t                trig_detectors;
	logic                    trig_external;
	logic                    arm_external;

	// ======================================================================
	// Internal signals
	logic                    wr_arm_lines;
	logic                    wr_trig_lines;
	logic                    wr_arm_event;
	logic                    wr_trig_out;
	logic                    wr_detectors;
	logic                    wr_source;
	line_num_t               w_in_line;
	line_num_t               w_out_line;
	logic [`RTR_ARM_EV_W-1:0] w_arm_event;
	logic                    arm_in_pulse;
	logic                    trig_in_pulse;
	logic                    arm_fire;
	logic                    trig_fire;
	logic [`RTR_LINE_COUNT-1:0] arm_onehot;
	logic [`RTR_LINE_COUNT-1:0] trig_onehot;
	logic [`RTR_LINE_COUNT-1:0] next_lines;
	sdm_set_t                held;
	sdm_set_t                next_go;
	logic                    arm_held;
	logic                    next_arm_go;
	logic [`RTR_DATA_W-1:0]  next_rd_data;
	logic [`RTR_LINE_COUNT-1:0] line_level;

	// ======================================================================
	// Helpers

	// A line number outside one to four leaves the selection unchanged.
	function automatic line_num_t pick_line(line_num_t req, line_num_t old);
		if (req >= `RTR_LINE_FIRST && req <= `RTR_LINE_LAST)
			return req;
		else
			return old;
	endfunction

	// Event list write: named events win over none; none alone clears;
	// an empty list is ignored.
	function automatic sdm_set_t take_list(logic [`RTR_DATA_W-1:0] d,
		sdm_set_t old);
		if (d[`RTR_LIST_W-1:0] != `RTR_LIST_RESET)
			return sdm_set_t'(d[`RTR_LIST_W-1:0]);
		else if (d[`RTR_LIST_NONE_BIT])
			return sdm_set_t'(`RTR_LIST_RESET);
		else
			return old;
	endfunction

	// Turns a line number into a one-hot line drive for one pulse.
	function automatic logic [`RTR_LINE_COUNT-1:0] steer(line_num_t num,
		logic fire);
		logic [`RTR_LINE_COUNT-1:0] v;
		v = '0;
		if (fire)
			v[2'(num - `RTR_LINE_FIRST)] = 1'b1;
		return v;
	endfunction

	// ======================================================================
	// Write decode
	assign wr_arm_lines  = bus_req_in.wr && bus_req_in.addr == `RTR_ARM_LINES;
	assign wr_trig_lines = bus_req_in.wr &&
		bus_req_in.addr == `RTR_TRIG_LINES;
	assign wr_arm_event  = bus_req_in.wr && bus_req_in.addr == `RTR_ARM_EVENT;
	assign wr_trig_out   = bus_req_in.wr &&
		bus_req_in.addr == `RTR_TRIG_OUT_EVENTS;
	assign wr_detectors  = bus_req_in.wr &&
		bus_req_in.addr == `RTR_TRIG_DETECTORS;
	assign wr_source     = bus_req_in.wr &&
		bus_req_in.addr == `RTR_CONTROL_SOURCE;

	assign w_in_line   = bus_req_in.wdata[`RTR_IN_LINE_LSB +: `RTR_LINE_W];
	assign w_out_line  = bus_req_in.wdata[`RTR_OUT_LINE_LSB +: `RTR_LINE_W];
	assign w_arm_event = bus_req_in.wdata[`RTR_ARM_EV_W-1:0];

	// ======================================================================
	// Line selections
	always_ff @(posedge ref_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			arm_in_line  <= `RTR_IN_LINE_RESET;
			arm_out_line <= `RTR_OUT_LINE_RESET;
		end
		else if (wr_arm_lines)
		begin
			arm_in_line  <= pick_line(w_in_line, arm_in_line);   // [RULE1]
			arm_out_line <= pick_line(w_out_line, arm_out_line); // [RULE2]
		end
	end

	always_ff @(posedge ref_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			trig_in_line  <= `RTR_IN_LINE_RESET;
			trig_out_line <= `RTR_OUT_LINE_RESET;
		end
		else if (wr_trig_lines)
		begin
			trig_in_line  <= pick_line(w_in_line, trig_in_line);   // [RULE1]
			trig_out_line <= pick_line(w_out_line, trig_out_line); // [RULE2]
		end
	end

	// ======================================================================
	// Output event selections
	always_ff @(posedge ref_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			arm_event_mode <= `RTR_ARM_EV_NONE;
		else if (wr_arm_event && (w_arm_event == `RTR_ARM_EV_NONE ||
			w_arm_event == `RTR_ARM_EV_ENTER ||
			w_arm_event == `RTR_ARM_EV_LEAVE))
			arm_event_mode <= w_arm_event;
	end

	always_ff @(posedge ref_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			trig_out_events <= sdm_set_t'(`RTR_LIST_RESET);
		else if (wr_trig_out)
			trig_out_events <= take_list(bus_req_in.wdata,
				trig_out_events); // [RULE10] [RULE11]
	end

	// ======================================================================
	// Detector enables and control sources
	always_ff @(posedge ref_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			trig_detectors <= sdm_set_t'(`RTR_LIST_RESET);
		else if (wr_detectors)
			trig_detectors <= take_list(bus_req_in.wdata, trig_detectors);
	end

	always_ff @(posedge ref_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			trig_external <= 1'b0;
			arm_external  <= 1'b0;
		end
		else if (wr_source)
		begin
			trig_external <= bus_req_in.wdata[`RTR_CS_TRIG_BIT];
			arm_external  <= bus_req_in.wdata[`RTR_CS_ARM_BIT];
		end
	end

	// ======================================================================
	// Incoming trigger pulses
	line_pick arm_pick
	(
		.ref_clk_in  (ref_clk_in),
		.arst_n_in   (arst_n_in),
		.lines_in    (lines_in),
		.line_num_in (arm_in_line),
		.pulse_out   (arm_in_pulse)
	);

	line_pick trig_pick
	(
		.ref_clk_in  (ref_clk_in),
		.arst_n_in   (arst_n_in),
		.lines_in    (lines_in),
		.line_num_in (trig_in_line),
		.pulse_out   (trig_in_pulse)
	);

	// ======================================================================
	// Detectors: a request gets a one-cycle go pulse, repeated every other clock while it stays up;
	// with the external source selected an enabled detector waits for an input pulse.
	assign held = trig_external ? trig_detectors :
		sdm_set_t'(`RTR_LIST_RESET);
	assign arm_held = arm_external;

	always_comb
	begin
		next_go = detector_req_in & ~detector_go_out &
			(~held | {`RTR_LIST_W{trig_in_pulse}}); // [RULE12]
		next_arm_go = arm_wait_in && !arm_go_out &&
			(!arm_held || arm_in_pulse);
	end

	always_ff @(posedge ref_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			detector_go_out <= sdm_set_t'(`RTR_LIST_RESET);
			arm_go_out      <= 1'b0;
		end
		else
		begin
			detector_go_out <= next_go;
			arm_go_out      <= next_arm_go;
		end
	end

	// ======================================================================
	// Output pulses
	always_comb
	begin
		arm_fire = 1'b0;
		case (arm_event_mode)
			`RTR_ARM_EV_ENTER:
				arm_fire = model_events_in.enter_trigger_layer_event; // [RULE4]
			`RTR_ARM_EV_LEAVE:
				arm_fire = model_events_in.leave_trigger_layer_event; // [RULE5]
			default:
				arm_fire = 1'b0; // [RULE6]
		endcase
	end

	// Each enabled step fires on its own completion.
	assign trig_fire = |(trig_out_events &
		model_events_in.step_done); // [RULE7] [RULE8] [RULE9] [RULE10]

	assign arm_onehot  = steer(arm_out_line, arm_fire);
	assign trig_onehot = steer(trig_out_line, trig_fire);
	assign next_lines  = arm_onehot | trig_onehot;

	// The line is driven high only for the cycle of a pulse.
	always_ff @(posedge ref_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			lines_out    <= '0;
			lines_oe_out <= '0;
		end
		else
		begin
			lines_out    <= next_lines; // [RULE13]
			lines_oe_out <= next_lines; // [RULE13]
		end
	end

	// ======================================================================
	// Read back
	always_ff @(posedge ref_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			line_level <= '0;
		else
			line_level <= lines_in;
	end

	always_comb
	begin
		next_rd_data = '0;
		case (bus_req_in.addr)
			`RTR_ARM_LINES:
			begin
				next_rd_data[`RTR_IN_LINE_LSB +: `RTR_LINE_W]  = arm_in_line;
				next_rd_data[`RTR_OUT_LINE_LSB +: `RTR_LINE_W] = arm_out_line;
			end
			`RTR_TRIG_LINES:
			begin
				next_rd_data[`RTR_IN_LINE_LSB +: `RTR_LINE_W]  = trig_in_line;
				next_rd_data[`RTR_OUT_LINE_LSB +: `RTR_LINE_W] = trig_out_line;
			end
			`RTR_ARM_EVENT:
				next_rd_data[`RTR_ARM_EV_W-1:0] = arm_event_mode;
			`RTR_TRIG_OUT_EVENTS:
			begin
				next_rd_data[`RTR_LIST_W-1:0] = trig_out_events;
				next_rd_data[`RTR_LIST_NONE_BIT] =
					(trig_out_events == sdm_set_t'(`RTR_LIST_RESET));
			end
			`RTR_TRIG_DETECTORS:
			begin
				next_rd_data[`RTR_LIST_W-1:0] = trig_detectors;
				next_rd_data[`RTR_LIST_NONE_BIT] =
					(trig_detectors == sdm_set_t'(`RTR_LIST_RESET));
			end
			`RTR_CONTROL_SOURCE:
			begin
				next_rd_data[`RTR_CS_TRIG_BIT] = trig_external;
				next_rd_data[`RTR_CS_ARM_BIT]  = arm_external;
			end
			`RTR_STATUS:
			begin
				next_rd_data[`RTR_LIST_W-1:0] = detector_req_in & held;
				next_rd_data[`RTR_ST_ARM_WAIT_BIT] = arm_wait_in && arm_held;
				next_rd_data[`RTR_ST_LEVEL_LSB +: `RTR_LINE_COUNT] =
					line_level;
			end
			default:
				next_rd_data = '0;
		endcase
	end

	always_ff @(posedge ref_clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			rd_data_out <= '0;
		else if (bus_req_in.rd)
			rd_data_out <= next_rd_data;
		else
			rd_data_out <= '0;
	end

endmodule // trigger_line_event_router

//--- trigger_line_event_router_tb.sv
// Self-checking bench for the trigger line event router.
`timescale 1ns/10ps
module trigger_line_event_router_tb;
	import trigger_router_pkg::*;
	logic          ref_clk_in;
	logic          arst_n_in = 1'b0;
	reg_req_t      req = '0;
	logic [7:0]    rd_data;
	model_events_t ev = '0;
	model_events_t e;
	sdm_set_t      det_req = '0;
	sdm_set_t      det_go;
	logic          arm_wait = 1'b0;
	logic          arm_go;
	logic [3:0]    lines;
	logic [3:0]    dev_out;
	logic [3:0]    dev_oe;
	logic [4:0]    ra [7] = '{5'h00, 5'h04, 5'h08, 5'h0C, 5'h10, 5'h14, 5'h1C};
	logic [7:0]    rx [7] = '{8'h21, 8'h21, 8'h00, 8'h08, 8'h08, 8'h00, 8'h00};
	int            fails = 0;
	int            num_checks = 0;
	int            n;

	trigger_line_event_router trigger_line_event_router_inst
	(
		.ref_clk_in      (ref_clk_in),
		.arst_n_in       (arst_n_in),
		.bus_req_in      (req),
		.rd_data_out     (rd_data),
		.model_events_in (ev),
		.detector_req_in (det_req),
		.arm_wait_in     (arm_wait),
		.detector_go_out (det_go),
		.arm_go_out      (arm_go),
		.lines_in        (lines),
		.lines_out       (dev_out),
		.lines_oe_out    (dev_oe)
	);
	trig_line_peer trig_line_peer_inst
	(
		.ref_clk_in (ref_clk_in),
		.dev_out_in (dev_out),
		.dev_oe_in  (dev_oe),
		.level_out  (lines)
	);

	// ======================================================================
	// Access tasks
	task automatic check(input string what, input logic [7:0] seen,
		input logic [7:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			fails++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge ref_clk_in);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge ref_clk_in);
		req.wr <= 1'b0;
	endtask
	task automatic rd(input logic [4:0] a, input logic [7:0] exp);
		@(posedge ref_clk_in);
		req.addr <= a;
		req.rd <= 1'b1;
		@(posedge ref_clk_in);
		req.rd <= 1'b0;
		#1;
		check($sformatf("reg %h", a), rd_data, exp);
	endtask
	task automatic fire_ev(input model_events_t x, input logic [3:0] exp);
		@(posedge ref_clk_in);
		ev <= x;
		@(posedge ref_clk_in);
		ev <= '0;
		#1;
		check("lines_out", dev_out, exp);
		check("lines_oe_out", dev_oe, exp);
		@(posedge ref_clk_in);
		#1;
		check("lines_out after", dev_out, 4'h0);
	endtask
	task automatic wait_go(output int cnt);
		cnt = 0;
		while (cnt < 8 && det_go === 3'h0 && arm_go !== 1'b1)
		begin
			@(posedge ref_clk_in);
			#1;
			cnt++;
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d fails %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// ======================================================================
	// Clock, watchdog and tests
	initial
	begin
		ref_clk_in = 1'b0;
		forever #5 ref_clk_in = ~ref_clk_in;
	end
	initial
	begin
		#100000;
		fails++;
		wrap_up();
	end
	initial
	begin
		repeat (5) @(posedge ref_clk_in);
		arst_n_in <= 1'b1;
		wr(5'h1C, 8'hFF);
		for (int i = 0; i < 7; i++)
			rd(ra[i], rx[i]);
		wr(5'h00, 8'h43);
		rd(5'h00, 8'h43);
		wr(5'h00, 8'h05);
		rd(5'h00, 8'h43);
		rd(5'h04, 8'h21);
		for (int c = 0; c < 3; c++)
		begin
			wr(5'h08, 8'(c));
			e = '0;
			e.enter_trigger_layer_event = 1'b1;
			fire_ev(e, (c == 1) ? 4'h8 : 4'h0);
			e = '0;
			e.leave_trigger_layer_event = 1'b1;
			fire_ev(e, (c == 2) ? 4'h8 : 4'h0);
		end
		wr(5'h08, 8'h03);
		rd(5'h08, 8'h02);
		// Input line 1 and output line 3 stay apart.
		wr(5'h04, 8'h31);
		for (int v = 1; v < 8; v++)
		begin
			wr(5'h0C, 8'(v));
			rd(5'h0C, 8'(v));
			for (int b = 0; b < 3; b++)
			begin
				e = '0;
				e.step_done = sdm_set_t'(3'(1 << b));
				fire_ev(e, v[b] ? 4'h4 : 4'h0);
			end
		end
		e = '0;
		e.leave_trigger_layer_event = 1'b1;
		e.step_done = 3'h7;
		fire_ev(e, 4'hC);
		wr(5'h0C, 8'h0D);
		rd(5'h0C, 8'h05);
		wr(5'h0C, 8'h08);
		rd(5'h0C, 8'h08);
		wr(5'h0C, 8'h00);
		rd(5'h0C, 8'h08);
		e.leave_trigger_layer_event = 1'b0;
		fire_ev(e, 4'h0);
		// Two back to back leave events give a two-cycle line drive.
		e = '0;
		e.leave_trigger_layer_event = 1'b1;
		@(posedge ref_clk_in);
		ev <= e;
		repeat (2) @(posedge ref_clk_in);
		ev <= '0;
		#1;
		check("long pulse", dev_out, 8'h08);
		@(posedge ref_clk_in);
		#1;
		check("long pulse end", dev_out, 8'h00);
		wr(5'h10, 8'h02);
		wr(5'h14, 8'h01);
		@(posedge ref_clk_in);
		det_req <= 3'h1;
		wait_go(n);
		check("pass count", 8'(n), 8'h01);
		check("go", det_go, 8'h01);
		@(posedge ref_clk_in);
		det_req <= 3'h2;
		repeat (4) @(posedge ref_clk_in);
		rd(5'h18, 8'h02);
		check("held go", det_go, 8'h00);
		fork
			trig_line_peer_inst.fire(1);
			wait_go(n);
		join
		check("held count", 8'(n), 8'h03);
		check("held go", det_go, 8'h02);
		@(posedge ref_clk_in);
		det_req <= 3'h0;
		wr(5'h14, 8'h00);
		@(posedge ref_clk_in);
		det_req <= 3'h2;
		wait_go(n);
		check("immediate count", 8'(n), 8'h01);
		@(posedge ref_clk_in);
		det_req <= 3'h0;
		wr(5'h14, 8'h02);
		@(posedge ref_clk_in);
		arm_wait <= 1'b1;
		repeat (3) @(posedge ref_clk_in);
		rd(5'h18, 8'h08);
		fork
			trig_line_peer_inst.fire(3);
			wait_go(n);
		join
		check("arm count", 8'(n), 8'h03);
		check("arm go", arm_go, 8'h01);
		@(posedge ref_clk_in);
		arm_wait <= 1'b0;
		repeat (3) @(posedge ref_clk_in);
		wrap_up();
	end
endmodule // trigger_line_event_router_tb

//--- trigger_router_map.svh
// Register offsets, field positions, codes and reset values of the router.
`ifndef TRIGGER_ROUTER_MAP_SVH
`define TRIGGER_ROUTER_MAP_SVH

// ==========================================================================
// Bus geometry
`define RTR_ADDR_W          5
`define RTR_DATA_W          8

// ==========================================================================
// Register offsets
`define RTR_ARM_LINES       5'h00
`define RTR_TRIG_LINES      5'h04
`define RTR_ARM_EVENT       5'h08
`define RTR_TRIG_OUT_EVENTS 5'h0C
`define RTR_TRIG_DETECTORS  5'h10
`define RTR_CONTROL_SOURCE  5'h14
`define RTR_STATUS          5'h18

// ==========================================================================
// Line selection fields
`define RTR_IN_LINE_LSB     0
`define RTR_OUT_LINE_LSB    4
`define RTR_LINE_W          3
`define RTR_LINE_FIRST      3'h1
`define RTR_LINE_LAST       3'h4
`define RTR_LINE_COUNT      4
`define RTR_IN_LINE_RESET   3'h1
`define RTR_OUT_LINE_RESET  3'h2

// ==========================================================================
// Arm layer output event codes
`define RTR_ARM_EV_W        2
`define RTR_ARM_EV_NONE     2'h0
`define RTR_ARM_EV_ENTER    2'h1
`define RTR_ARM_EV_LEAVE    2'h2

// ==========================================================================
// Event list fields: bits 2..0 measure, delay, source; bit 3 none
`define RTR_LIST_W          3
`define RTR_LIST_NONE_BIT   3
`define RTR_LIST_RESET      3'h0

// ==========================================================================
// Control source fields
`define RTR_CS_TRIG_BIT     0
`define RTR_CS_ARM_BIT      1

// ==========================================================================
// Status fields
`define RTR_ST_ARM_WAIT_BIT 3
`define RTR_ST_LEVEL_LSB    4

`endif

//--- trigger_router_pkg.sv
// Types shared by the trigger line event router and its sub-modules.
package trigger_router_pkg;

	typedef logic [2:0] line_num_t;

	// Source-delay-measure cycle step set, used for output events,
	// detector enables and detector requests.
	typedef struct packed {
		logic measure;
		logic delay;
		logic source;
	} sdm_set_t;

	// Progress events reported by the trigger model sequencer.
	typedef struct packed {
		logic     enter_trigger_layer_event;
		logic     leave_trigger_layer_event;
		sdm_set_t step_done;
	} model_events_t;

	// One register bus request.
	typedef struct packed {
		logic [4:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} reg_req_t;

endpackage
